// ---- rtl/hff_pkg.sv ----
package hff_pkg;

	// buffer geometry
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned CNT_W = 7;
	localparam int unsigned RX_DEPTH = 64;
	localparam int unsigned RX_BLOCK_BYTES = 8;
	localparam int unsigned RX_BLOCKS = 8;
	localparam int unsigned TX_DEPTH = 64;
	localparam int unsigned MAX_FRAMES = 8;
	localparam int unsigned FRM_W = 3;

	// hand-off thresholds
	localparam logic [6:0] RX_PORTION = 7'h20;
	localparam logic [6:0] TX_HALF = 7'h20;
	localparam logic [3:0] FRAMES_FULL = 4'h8;

	// reset values
	localparam logic [6:0] CNT_RST = 7'h00;
	localparam logic [3:0] NFR_RST = 4'h0;
	localparam logic [2:0] PTR_RST = 3'h0;

	// host bus styles, gray along the strap order
	typedef enum logic [1:0] {
		HFF_BUS_NONMUX = 2'b00,
		HFF_BUS_MUX = 2'b01,
		HFF_BUS_RDWR = 2'b11
	} hff_bus_style_t;

endpackage : hff_pkg

// ---- rtl/hff_stream_if.sv ----
`timescale 1ns/1ns
interface hff_stream_if #(
	parameter int W = 8,
	parameter int LW = 7
);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	logic [LW-1:0] level;

	// the buffer itself
	modport buf_side(input in_valid, input in_data, input out_ready,
		output in_ready, output out_valid, output out_data, output level);
	// the logic that fills and drains it
	modport user_side(output in_valid, output in_data, output out_ready,
		input in_ready, input out_valid, input out_data, input level);
endinterface : hff_stream_if

// ---- rtl/hff_fifo.sv ----
`timescale 1ns/1ns
module hff_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// stream ports
	hff_stream_if.buf_side s
);
	localparam int AW = $clog2(DEPTH);

	// pointer wraps naturally; depth must be a power of two
	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return p + 1'b1;
	endfunction : ptr_inc

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic ov_q, ov_d;
	logic [WIDTH-1:0] od_q;
	logic push, load;

	// ready and level from flops only
	assign s.level = (AW+1)'(cnt_q) + (AW+1)'(ov_q);
	assign s.in_ready = s.level < (AW+1)'(DEPTH);
	assign s.out_valid = ov_q;
	assign s.out_data = od_q;

	// output register refills whenever it is empty or being taken
	always_comb begin
		push = s.in_valid && s.in_ready;
		load = (cnt_q != '0) && (!ov_q || s.out_ready);
		wr_d = push ? ptr_inc(wr_q) : wr_q;
		rd_d = load ? ptr_inc(rd_q) : rd_q;
		cnt_d = cnt_q;
		if (push && !load) begin
			cnt_d = cnt_q + 1'b1;
		end else if (load && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
		ov_d = load ? 1'b1 : (s.out_ready ? 1'b0 : ov_q);
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ov_q <= 1'b0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			ov_q <= ov_d;
		end
	end

	// storage and registered read data, no reset needed on the array
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_q] <= s.in_data;
		end
		if (load) begin
			od_q <= mem[rd_q];
		end
	end

	a_fifo_no_over: assert property (@(posedge clk_i) disable iff (!nrst_i)
		s.level <= (AW+1)'(DEPTH))
		else $error("fifo holds more than its depth");
endmodule : hff_fifo

// ---- rtl/hff_frame_fifo.sv ----
`timescale 1ns/1ns
// What this block does
// - receive buffer of 64 bytes built from eight chained 8-byte blocks
// - a frame of up to 64 bytes fits wholly in the receive buffer
// - after 32 bytes of a frame, interrupt host; host reads available bytes
// - long frames interrupt once per 32 bytes; host drains 32-byte portions
// - up to eight short frames queued at once, behind the one granted to the host
// - each interrupt hands one frame or one 32-byte portion; the rest wait in order
// - transmit buffer of 64 bytes in two 32-byte halves
// - host requests transmit after writing 32 bytes; device then sends it
// - a request without message end raises an interrupt for the next block
// - external DMA supported, enabled by a configuration bit
module hff_frame_fifo
	import hff_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// serial receiver side
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_eof_i,
	output logic rx_ready_o,
	// host receive side
	input wire logic host_rd_i,
	output logic [7:0] host_rdata_o,
	output logic host_rvalid_o,
	output logic [6:0] rx_avail_o,
	output logic rx_irq_o,
	// host transmit side
	input wire logic host_wr_i,
	input wire logic [7:0] host_wdata_i,
	output logic host_wready_o,
	input wire logic tx_req_i,
	input wire logic tx_end_i,
	output logic tx_irq_o,
	// serial transmitter side
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	input wire logic tx_ready_i,
	// straps and configuration
	input wire logic bus_multiplex_select_i,
	input wire logic bus_rdwr_select_i,
	output hff_bus_style_t bus_style_o,
	input wire logic dma_enable_i,
	output logic dma_rx_req_o,
	output logic dma_tx_req_o
);

	// strap decode: multiplexed wins over separate strobes
	function automatic hff_bus_style_t style_of(input logic mux, input logic rdwr);
		if (mux) begin
			return HFF_BUS_MUX;
		end
		return rdwr ? HFF_BUS_RDWR : HFF_BUS_NONMUX;
	endfunction : style_of

	hff_stream_if #(.W(BYTE_W), .LW(CNT_W)) rxs ();
	hff_stream_if #(.W(BYTE_W), .LW(CNT_W)) txs ();

	// 64 bytes as eight 8-byte blocks: pointer high bits pick the block,
	// so crossing a block boundary chains into the next one
	hff_fifo #(.WIDTH(BYTE_W), .DEPTH(RX_BLOCK_BYTES * RX_BLOCKS)) u_rx_buf (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.s(rxs)
	);

	// two 32-byte halves back to back in one ring
	hff_fifo #(.WIDTH(BYTE_W), .DEPTH(TX_DEPTH)) u_tx_buf (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.s(txs)
	);

	// ---------------- receive state ----------------
	logic [6:0] len_q [MAX_FRAMES];
	logic [2:0] head_q, head_d, tail_q, tail_d;
	logic [3:0] nfr_q, nfr_d;
	logic [6:0] cur_q, cur_d, avail_q, avail_d;
	logic rx_ready_q, rx_ready_d, rx_irq_q, rx_irq_d;
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic len_we;
	logic [6:0] len_wv;
	logic rx_push, rx_pop, part_grant;

	assign rxs.in_valid = rx_valid_i && rx_ready_q;
	assign rxs.in_data = rx_data_i;
	assign rxs.out_ready = rx_pop;

	// grants happen only when the host holds nothing, so one frame per interrupt
	always_comb begin
		rx_push = rx_valid_i && rx_ready_q && rxs.in_ready;
		rx_pop = host_rd_i && (avail_q != CNT_RST) && rxs.out_valid;
		head_d = head_q;
		tail_d = tail_q;
		nfr_d = nfr_q;
		cur_d = cur_q;
		avail_d = avail_q;
		rx_irq_d = 1'b0;
		part_grant = 1'b0;
		len_we = 1'b0;
		len_wv = CNT_RST;
		if (rx_pop) begin
			avail_d = avail_q - 7'h01;
		end
		if (avail_q == CNT_RST) begin
			if (nfr_q != NFR_RST) begin
				avail_d = len_q[head_q];
				head_d = head_q + 3'h1;
				nfr_d = nfr_d - 4'h1;
				rx_irq_d = 1'b1;
			end else if (cur_q >= RX_PORTION) begin
				avail_d = RX_PORTION;
				cur_d = cur_q - RX_PORTION;
				rx_irq_d = 1'b1;
				part_grant = 1'b1;
			end
		end
		if (rx_push) begin
			if (rx_eof_i) begin
				len_we = 1'b1;
				len_wv = cur_d + 7'h01;
				tail_d = tail_q + 3'h1;
				nfr_d = nfr_d + 4'h1;
				cur_d = CNT_RST;
			end else begin
				cur_d = cur_d + 7'h01;
			end
		end
		// registered ready leaves a one-byte margin; the frame limit is taken from the next frame count, nfr_d
		rx_ready_d = (nfr_d < FRAMES_FULL) && (rxs.level < 7'(RX_DEPTH - 1));
		rdata_d = rx_pop ? rxs.out_data : rdata_q;
		rvalid_d = rx_pop;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			head_q <= PTR_RST;
			tail_q <= PTR_RST;
			nfr_q <= NFR_RST;
			cur_q <= CNT_RST;
			avail_q <= CNT_RST;
			rx_ready_q <= 1'b0;
			rx_irq_q <= 1'b0;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			head_q <= head_d;
			tail_q <= tail_d;
			nfr_q <= nfr_d;
			cur_q <= cur_d;
			avail_q <= avail_d;
			rx_ready_q <= rx_ready_d;
			rx_irq_q <= rx_irq_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	// frame length queue, read only through the head pointer
	always_ff @(posedge clk_i) begin
		if (len_we) begin
			len_q[tail_q] <= len_wv;
		end
	end

	// ---------------- transmit state ----------------
	logic [6:0] wcnt_q, wcnt_d, rel_q, rel_d, eleft_q, eleft_d;
	logic epend_q, epend_d;
	logic wready_q, wready_d, tx_irq_q, tx_irq_d;
	logic txv_q, txv_d, txl_q, txl_d;
	logic [7:0] txd_q, txd_d;
	logic tx_push, req_ok, tx_move;

	assign txs.in_valid = host_wr_i && wready_q;
	assign txs.in_data = host_wdata_i;
	assign txs.out_ready = tx_move;

	// a second message end is refused until the first has gone out
	always_comb begin
		tx_push = host_wr_i && wready_q && txs.in_ready;
		req_ok = tx_req_i && !epend_q && ((wcnt_q != CNT_RST) || tx_end_i);
		tx_move = (!txv_q || tx_ready_i) && (rel_q != CNT_RST) && txs.out_valid;
		wcnt_d = wcnt_q;
		rel_d = rel_q;
		eleft_d = eleft_q;
		epend_d = epend_q;
		tx_irq_d = 1'b0;
		txd_d = txd_q;
		txl_d = txl_q;
		txv_d = txv_q;
		if (tx_move) begin
			rel_d = rel_q - 7'h01;
			txd_d = txs.out_data;
			txv_d = 1'b1;
			txl_d = epend_q && (eleft_q == 7'h01);
			if (epend_q) begin
				eleft_d = eleft_q - 7'h01;
				epend_d = eleft_q != 7'h01;
			end
		end else if (tx_ready_i) begin
			txv_d = 1'b0;
			txl_d = 1'b0;
		end
		if (req_ok) begin
			rel_d = rel_d + wcnt_q;
			wcnt_d = CNT_RST;
			if (tx_end_i) begin
				// rel_d already holds this block, so it is the whole rest of the message
				epend_d = rel_d != CNT_RST;
				eleft_d = rel_d;
			end else begin
				tx_irq_d = 1'b1;
			end
		end
		if (tx_push) begin
			wcnt_d = wcnt_d + 7'h01;
		end
		// host fills one half before asking to send
		wready_d = (wcnt_d < TX_HALF) && (txs.level < 7'(TX_DEPTH - 1));
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			wcnt_q <= CNT_RST;
			rel_q <= CNT_RST;
			eleft_q <= CNT_RST;
			epend_q <= 1'b0;
			wready_q <= 1'b0;
			tx_irq_q <= 1'b0;
			txv_q <= 1'b0;
			txl_q <= 1'b0;
			txd_q <= 8'h00;
		end else begin
			wcnt_q <= wcnt_d;
			rel_q <= rel_d;
			eleft_q <= eleft_d;
			epend_q <= epend_d;
			wready_q <= wready_d;
			tx_irq_q <= tx_irq_d;
			txv_q <= txv_d;
			txl_q <= txl_d;
			txd_q <= txd_d;
		end
	end

	// ---------------- straps and DMA ----------------
	hff_bus_style_t style_q, style_d;
	logic strap_done_q, strap_done_d;
	logic dma_rx_q, dma_rx_d, dma_tx_q, dma_tx_d;

	// straps caught once, on the first edge after reset is released
	always_comb begin
		strap_done_d = 1'b1;
		style_d = strap_done_q ? style_q :
			style_of(bus_multiplex_select_i, bus_rdwr_select_i);
		dma_rx_d = dma_enable_i && (avail_d != CNT_RST);
		dma_tx_d = dma_enable_i && wready_d;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			style_q <= HFF_BUS_NONMUX;
			strap_done_q <= 1'b0;
			dma_rx_q <= 1'b0;
			dma_tx_q <= 1'b0;
		end else begin
			style_q <= style_d;
			strap_done_q <= strap_done_d;
			dma_rx_q <= dma_rx_d;
			dma_tx_q <= dma_tx_d;
		end
	end

	// outputs straight from flops
	assign rx_ready_o = rx_ready_q;
	assign host_rdata_o = rdata_q;
	assign host_rvalid_o = rvalid_q;
	assign rx_avail_o = avail_q;
	assign rx_irq_o = rx_irq_q;
	assign host_wready_o = wready_q;
	assign tx_irq_o = tx_irq_q;
	assign tx_valid_o = txv_q;
	assign tx_data_o = txd_q;
	assign tx_last_o = txl_q;
	assign bus_style_o = style_q;
	assign dma_rx_req_o = dma_rx_q;
	assign dma_tx_req_o = dma_tx_q;

	// ---------------- checks ----------------
	a_rx_cap_bound: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rxs.level <= 7'(RX_DEPTH))
		else $error("receive buffer above 64 bytes");
	a_rx_no_loss: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rx_ready_q |-> rxs.in_ready)
		else $error("receive ready while buffer full");
	a_part_grant: assert property (@(posedge clk_i) disable iff (!nrst_i)
		part_grant |=> rx_irq_o && avail_q == RX_PORTION)
		else $error("partial grant not 32 bytes with interrupt");
	a_portion_size: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(rx_irq_o) && $past(nfr_q) == NFR_RST |-> avail_q == RX_PORTION)
		else $error("portion grant of wrong size");
	a_frame_cap: assert property (@(posedge clk_i) disable iff (!nrst_i)
		nfr_q <= FRAMES_FULL)
		else $error("more than eight frames queued");
	a_one_frame: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rx_irq_o |-> $past(avail_q) == CNT_RST && avail_q != CNT_RST)
		else $error("grant while host still holds bytes");
	a_tx_half: assert property (@(posedge clk_i) disable iff (!nrst_i)
		wcnt_q <= TX_HALF)
		else $error("more than a half written before request");
	a_tx_release: assert property (@(posedge clk_i) disable iff (!nrst_i)
		req_ok && !tx_end_i |=> wcnt_q == 7'($past(tx_push)) ##[0:2] rel_q != CNT_RST || txv_q)
		else $error("transmit request did not release block");
	a_tx_next_irq: assert property (@(posedge clk_i) disable iff (!nrst_i)
		req_ok && !tx_end_i |=> tx_irq_o ##1 (!tx_irq_o || $past(req_ok && !tx_end_i)))
		else $error("missing next block interrupt");
	a_style_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
		strap_done_q |=> $stable(bus_style_o))
		else $error("bus style changed after capture");
	a_dma_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!$past(dma_enable_i) |-> !dma_rx_req_o && !dma_tx_req_o)
		else $error("DMA request while disabled");
	a_reset_empty: assert property (@(posedge clk_i)
		!nrst_i |=> nfr_q == NFR_RST && !rx_irq_o && !tx_irq_o && rxs.level == CNT_RST)
		else $error("buffers not empty after reset");
endmodule : hff_frame_fifo

// ---- testbench/hff_host_model.sv ----
`timescale 1ns/1ns
// host stand-in: drains whatever the buffer grants, at full or half rate
module hff_host_model (
	// clock
	input wire logic clk_i,
	// bench control
	input wire logic en_i,
	input wire logic slow_i,
	// buffer read port
	input wire logic [6:0] rx_avail_i,
	input wire logic host_rvalid_i,
	input wire logic [7:0] host_rdata_i,
	output logic host_rd_o
);
	logic [7:0] mem [0:255];
	int n = 0;
	logic ph = 1'b0;
	logic go;
	initial host_rd_o = 1'b0;
	// enable is taken at the edge, the grant after it settles; half rate stalls the buffer
	always @(posedge clk_i) begin
		go = en_i;
		#1;
		ph = ~ph;
		host_rd_o = go && (rx_avail_i != 7'h00) && (!slow_i || ph);
	end
	// keep answers in arrival order
	always @(posedge clk_i) begin
		if (host_rvalid_i === 1'b1) begin
			mem[n] <= host_rdata_i;
			n <= n + 1;
		end
	end
endmodule : hff_host_model

// ---- testbench/test_hdlc_frame_fifo_host_port.sv ----
`timescale 1ns/1ns
module test_hdlc_frame_fifo_host_port;
	import hff_pkg::*;
	// bench-driven inputs
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic rx_valid_i = 1'b0, rx_eof_i = 1'b0, host_wr_i = 1'b0, tx_req_i = 1'b0, tx_end_i = 1'b0;
	logic [7:0] rx_data_i = 8'h00, host_wdata_i = 8'h00;
	logic tx_ready_i = 1'b0, strap_m = 1'b0, strap_r = 1'b0, dma_en = 1'b0, hen = 1'b0;
	logic hslow = 1'b0;
	// design and host model outputs
	logic host_rd, rx_ready, host_rvalid, rx_irq, host_wready, tx_irq, tx_valid, tx_last;
	logic dma_rx, dma_tx;
	logic [7:0] host_rdata, tx_data;
	logic [6:0] rx_avail;
	hff_bus_style_t bus_style;
	int n_fail = 0;
	int num_checks = 0;
	int rx_irqs = 0;
	int tx_irqs = 0;
	int ntx = 0;
	logic [8:0] txq [0:255];

	always #5 clk_i = ~clk_i;

	hff_frame_fifo dut (.clk_i(clk_i), .nrst_i(nrst_i), .rx_valid_i(rx_valid_i),
		.rx_data_i(rx_data_i), .rx_eof_i(rx_eof_i), .rx_ready_o(rx_ready),
		.host_rd_i(host_rd), .host_rdata_o(host_rdata), .host_rvalid_o(host_rvalid),
		.rx_avail_o(rx_avail), .rx_irq_o(rx_irq), .host_wr_i(host_wr_i),
		.host_wdata_i(host_wdata_i), .host_wready_o(host_wready), .tx_req_i(tx_req_i),
		.tx_end_i(tx_end_i), .tx_irq_o(tx_irq), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
		.tx_last_o(tx_last), .tx_ready_i(tx_ready_i), .bus_multiplex_select_i(strap_m),
		.bus_rdwr_select_i(strap_r), .bus_style_o(bus_style), .dma_enable_i(dma_en),
		.dma_rx_req_o(dma_rx), .dma_tx_req_o(dma_tx));

	hff_host_model hm (.clk_i(clk_i), .en_i(hen), .slow_i(hslow), .rx_avail_i(rx_avail),
		.host_rvalid_i(host_rvalid), .host_rdata_i(host_rdata), .host_rd_o(host_rd));

	// count pulses and keep what the transmitter takes
	always @(posedge clk_i) begin
		if (rx_irq === 1'b1) rx_irqs <= rx_irqs + 1;
		if (tx_irq === 1'b1) tx_irqs <= tx_irqs + 1;
		if (tx_valid === 1'b1 && tx_ready_i === 1'b1) begin
			txq[ntx] <= {tx_last, tx_data};
			ntx <= ntx + 1;
		end
	end

	// the transmitter stalls every other cycle
	always @(posedge clk_i) tx_ready_i <= #1 ~tx_ready_i;

	task report_and_stop;
		if (n_fail == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk

	// bounded wait for a counter; a hang ends the run as a mismatch
	task automatic wait_n(ref int c, input int t);
		int k;
		k = 0;
		while (c < t && k < 2000) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		chk("wait count", t, c);
		if (c < t) report_and_stop();
	endtask : wait_n

	// ready is a register: seen high in the settled cycle, the next edge takes the transfer
	task automatic accepted(ref logic rdy);
		int k;
		k = 0;
		while (rdy !== 1'b1 && k < 500) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		if (k == 500) begin
			chk("ready timeout", 1, 0);
			report_and_stop();
		end
		@(posedge clk_i);
		#1;
	endtask : accepted

	task do_reset(input logic m, input logic r);
		nrst_i = 1'b0;
		strap_m = m;
		strap_r = r;
		repeat (6) @(posedge clk_i);
		#1 nrst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
	endtask : do_reset

	task send(input logic [7:0] base, input int len, input logic eof);
		rx_valid_i = 1'b1;
		for (int i = 0; i < len; i++) begin
			rx_data_i = base + 8'(i);
			rx_eof_i = eof && (i == len - 1);
			accepted(rx_ready);
		end
		rx_valid_i = 1'b0;
		rx_eof_i = 1'b0;
		// an idle edge keeps back-to-back sends from toggling valid in one step
		@(posedge clk_i);
		#1;
	endtask : send

	task write(input logic [7:0] base, input int len);
		host_wr_i = 1'b1;
		for (int i = 0; i < len; i++) begin
			host_wdata_i = base + 8'(i);
			accepted(host_wready);
		end
		host_wr_i = 1'b0;
	endtask : write

	task rd_check(input int n0, input logic [7:0] base, input int len);
		for (int i = 0; i < len; i++) chk("read byte", base + 8'(i), hm.mem[n0 + i]);
	endtask : rd_check

	// every strap setting, then the idle state after reset
	task t_reset;
		for (int s = 0; s < 4; s++) begin
			do_reset(s[0], s[1]);
			chk("bus style", s == 0 ? HFF_BUS_NONMUX : s[0] ? HFF_BUS_MUX : HFF_BUS_RDWR, bus_style);
			chk("idle outputs", 5'h18, {rx_ready, host_wready, rx_avail != 0, rx_irq, tx_valid});
		end
	endtask : t_reset

	// eight short frames stored while the host waits, handed over one by one
	task t_frames;
		int n0, i0;
		n0 = hm.n;
		i0 = rx_irqs;
		for (int f = 0; f < 8; f++) send(8'(f * 16), 4, 1'b1);
		repeat (4) @(posedge clk_i);
		#1;
		chk("irqs with host idle", i0 + 1, rx_irqs);
		chk("first grant", 7'h04, rx_avail);
		hen = 1'b1;
		wait_n(hm.n, n0 + 32);
		hen = 1'b0;
		repeat (4) @(posedge clk_i);
		#1;
		chk("irqs after drain", i0 + 8, rx_irqs);
		for (int f = 0; f < 8; f++) rd_check(n0 + 4 * f, 8'(f * 16), 4);
	endtask : t_frames

	// a 72-byte frame granted in 32-byte portions plus its tail
	task t_long;
		int n0, i0, len;
		n0 = hm.n;
		hslow = 1'b1;
		for (int p = 0; p < 3; p++) begin
			i0 = rx_irqs;
			len = p < 2 ? 32 : 8;
			send(8'(p * 32 + 64), len, p == 2);
			wait_n(rx_irqs, i0 + 1);
			chk("portion grant", len, rx_avail);
			hen = 1'b1;
			wait_n(hm.n, n0 + 32 * p + len);
			hen = 1'b0;
		end
		rd_check(n0, 8'h40, 72);
	endtask : t_long

	// one half without end, then a short ended block
	task t_tx;
		int t0, i0;
		t0 = ntx;
		i0 = tx_irqs;
		write(8'h80, 32);
		chk("room after half", 0, host_wready);
		tx_req_i = 1'b1;
		@(posedge clk_i);
		#1;
		tx_req_i = 1'b0;
		chk("next block irq", 1, tx_irq);
		chk("room again", 1, host_wready);
		write(8'ha0, 10);
		tx_req_i = 1'b1;
		tx_end_i = 1'b1;
		@(posedge clk_i);
		#1;
		tx_req_i = 1'b0;
		tx_end_i = 1'b0;
		wait_n(ntx, t0 + 42);
		for (int i = 0; i < 42; i++) chk("sent byte", {i == 41, 8'h80 + 8'(i)}, txq[t0 + i]);
		chk("tx irqs", i0 + 1, tx_irqs);
	endtask : t_tx

	// dma requests follow room and grants
	task t_dma;
		int n0, i0;
		dma_en = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk("dma tx request", 1, dma_tx);
		chk("dma rx idle", 0, dma_rx);
		i0 = rx_irqs;
		send(8'h11, 3, 1'b1);
		wait_n(rx_irqs, i0 + 1);
		chk("dma rx request", 1, dma_rx);
		n0 = hm.n;
		hen = 1'b1;
		wait_n(hm.n, n0 + 3);
		hen = 1'b0;
		dma_en = 1'b0;
	endtask : t_dma

	initial begin
		t_reset();
		t_frames();
		t_long();
		t_tx();
		t_dma();
		report_and_stop();
	end
endmodule : test_hdlc_frame_fifo_host_port
